//--- verilog/port_cfg_defs.svh
`ifndef PORT_CFG_DEFS_SVH
`define PORT_CFG_DEFS_SVH
// Notes on behaviour
// [RULE1] sense codes: any, rise, fall, low, off
// [RULE2] sense code decides interrupt and event hits
// [RULE3] buffer off: pin unsampled, level reads zero
// [RULE4] low sense: events while high, none low
// [RULE5] buffer off only on first five ports
// [RULE6] software turns buffer off for analog pins
// [RULE7] group mask write updates masked pins only
// [RULE8] group mask clears after pin config write
// [RULE9] map a: high nibble vport1, low vport0
// [RULE10] map b: high nibble vport3, low vport2
// [RULE11] vport access acts on physical register
// [RULE12] map codes 0-4, 6, 11, 15 select ports
// [RULE13] alternate select moves output to pin 4
// [RULE14] rtc output enable drives port c pin 6
// [RULE15] event port field: off, c, reserved, e
// [RULE16] software keeps clock and event ports apart
// [RULE17] routed signal only on output pins
// [RULE18] rate select picks 1x, 2x, 4x clock
// [RULE19] clock port field: off, c, reserved, e
// [RULE20] clock wins over event on same pin
// [RULE21] software writes zero to reserved bits
// [RULE22] channel select picks event channel 0-3
// [RULE23] reserved codes act as inactive
// [RULE24] clock event control resets to zero
`define IDX_GROUP_MASK 10'h000
`define IDX_VMAP_A     10'h002
`define IDX_VMAP_B     10'h003
`define IDX_CLKEV      10'h004
`define IDX_EVENT_OUTPUT_CONTROL     10'h006
`define PINCFG_TAG     4'h1
`define VPORT_TAG      6'h08
`define RST_CLKEV      8'h00
`define RST_REG        8'h00
`define SENSE_ANY      3'h0
`define SENSE_RISE     3'h1
`define SENSE_FALL     3'h2
`define SENSE_LOW      3'h3
`define SENSE_OFF      3'h7
`define BUF_PORTS      3'h5
`define ROUTE_PC       2'h1
`define ROUTE_PE       2'h3
`define RATE_1X        2'h0
`define RATE_2X        2'h1
`define RATE_4X        2'h2
`define PIN_ALT        3'h4
`define PIN_DEF        3'h7
`define PIN_RTC        3'h6
`define CE_ALT_BIT     7
`define CE_RTC_BIT     6
`define CE_EVPORT_LSB  4
`define CE_RATE_LSB    2
`define CE_CLKPORT_LSB 0
`endif

//--- verilog/port_cfg_pkg.sv
package port_cfg_pkg;
  // one bit per pin, [port][pin]
  typedef logic [7:0][7:0] pin_bank_t;
  // pin configuration bytes, [port][pin]
  typedef logic [7:0][7:0][7:0] pin_cfg_t;
  // bus sequencer, one-hot
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_VPORT = 3'b010,
    ST_ACK   = 3'b100
  } bus_state_t;
  // forwarded physical port register access
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [2:0] port;
    logic [1:0] sel;
    logic [7:0] wdata;
  } vport_req_t;
  // override drive for one port
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] en;
  } alt_drive_t;
  // whole state of the block
  typedef struct packed {
    bus_state_t st;
    logic       pready;
    logic       pslverr;
    logic [31:0] prdata;
    logic [7:0] group_mask;
    logic [7:0] vmap_a;
    logic [7:0] vmap_b;
    logic [7:0] clkev;
    logic [1:0] evsel;
    pin_cfg_t   pincfg;
    pin_bank_t  sync1;
    pin_bank_t  sync2;
    pin_bank_t  prev;
    pin_bank_t  level;
    pin_bank_t  irq_hit;
    pin_bank_t  ev_hit;
    logic [2:0] div;
    logic       rtc_s1;
    logic       rtc_s2;
    vport_req_t req;
    alt_drive_t drv_c;
    alt_drive_t drv_e;
  } state_t;
endpackage : port_cfg_pkg

//--- verilog/port_cfg.sv
// Local design decision: the APB slave port.
`timescale 1ns/10ps
`include "port_cfg_defs.svh"
module port_cfg import port_cfg_pkg::*; (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // pads and system inputs
  input  wire pin_bank_t   pins_in,
  input  wire logic        rtc_clk_src,
  input  wire logic [3:0]  ev_channel,
  input  wire logic [7:0]  dir_c,
  input  wire logic [7:0]  dir_e,
  // physical port register answer
  input  wire logic [7:0]  vp_rdata,
  // per-pin results
  output pin_bank_t        sampled_levels,
  output pin_bank_t        sense_irq,
  output pin_bank_t        sense_event,
  output pin_cfg_t         pin_config,
  // forwarded register access
  output vport_req_t       vp_req,
  // special function drive
  output alt_drive_t       drive_c,
  output alt_drive_t       drive_e
);

  // the virtual windows share one decoder, so the
  // map code is turned into a port index in one place;
  // a clear valid bit makes the window refuse access
  // map code to physical port index, bit 3 = valid
  function automatic logic [3:0] map_decode(input logic [3:0] code);
    logic [3:0] r;
    r = 4'h0;
    // [RULE12] map code decode
    case (code)
      4'h0, 4'h1, 4'h2, 4'h3, 4'h4: r = {1'b1, code[2:0]};
      4'h6:    r = 4'hd;
      4'hb:    r = 4'he;
      4'hf:    r = 4'hf;
      // [RULE23] reserved map code
      default: r = 4'h0;
    endcase
    return r;
  endfunction : map_decode

  // interrupt and event hits differ only for low-level
  // sensing, where an event follows a high pin instead;
  // edge codes compare against the previous sample
  // sense evaluation, returns {irq, event}
  function automatic logic [1:0] sense_eval(input logic [2:0] code,
                                            input logic lvl,
                                            input logic old);
    logic [1:0] r;
    r = 2'h0;
    // [RULE1] sense code meaning
    case (code)
      `SENSE_ANY:  r = {2{lvl ^ old}};
      `SENSE_RISE: r = {2{lvl & ~old}};
      `SENSE_FALL: r = {2{~lvl & old}};
      // [RULE4] low sense events
      `SENSE_LOW:  r = {~lvl, lvl};
      // [RULE23] reserved and off codes
      default:     r = 2'h0;
    endcase
    return r;
  endfunction : sense_eval

  // both routed ports go through the same function, so
  // clock priority and direction gating stay identical;
  // the rtc clock is only ever offered to port c, the
  // caller passes a zero enable for the other port
  // override drive for one port of the clock/event router
  function automatic alt_drive_t route(input logic [1:0] want,
                                       input logic [7:0] ce,
                                       input logic       ev,
                                       input logic       clk,
                                       input logic       clk_ok,
                                       input logic       rtc_en,
                                       input logic       rtc,
                                       input logic [7:0] dir);
    alt_drive_t d;
    logic [2:0] pin;
    d = '0;
    // [RULE13] alternate pin choice
    pin = ce[`CE_ALT_BIT] ? `PIN_ALT : `PIN_DEF;
    // [RULE15] event port route
    if (ce[`CE_EVPORT_LSB +: 2] == want) begin
      d.out[pin] = ev;
      d.en[pin]  = 1'b1;
    end
    // [RULE19] clock port route
    // [RULE20] clock overrides event
    if (ce[`CE_CLKPORT_LSB +: 2] == want && clk_ok) begin
      d.out[pin] = clk;
      d.en[pin]  = 1'b1;
    end
    // [RULE14] rtc clock output
    if (rtc_en && ce[`CE_RTC_BIT]) begin
      d.out[`PIN_RTC] = rtc;
      d.en[`PIN_RTC]  = 1'b1;
    end
    // an input pin must never see a routed level, so the
    // enable and the level are both masked by direction
    // [RULE17] only on output pins
    d.en  = d.en & dir;
    d.out = d.out & d.en;
    return d;
  endfunction : route

  // all state lives in one packed struct: the comb block
  // builds a copy and the clocked block registers it, so
  // every output below comes straight from a flop
  state_t s;       // registered state
  state_t next_s;  // next state

  // next-state logic
  always_comb begin
    // word index of the access
    logic [9:0] idx;
    // local read data byte
    logic [7:0] rd;
    // write data byte
    logic [7:0] d;
    // write gated by byte strobe
    logic       wr;
    // input buffer turned off
    logic       isbuf;
    // effective sampled level
    logic       lvl;
    // sense result, irq and event
    logic [1:0] hit;
    // map code of addressed window
    logic [3:0] code;
    // decoded physical port
    logic [3:0] dec;
    // divided clock level
    logic       clk_lvl;
    // divided clock rate is legal
    logic       clk_ok;
    // selected event channel level
    logic       ev_lvl;
    idx     = paddr[11:2];
    rd      = 8'h00;
    d       = pwdata[7:0];
    wr      = pwrite & pstrb[0];
    isbuf   = 1'b0;
    lvl     = 1'b0;
    hit     = 2'h0;
    code    = 4'h0;
    dec     = 4'h0;
    clk_lvl = 1'b0;
    clk_ok  = 1'b0;
    ev_lvl  = 1'b0;
    next_s  = s;
    next_s.pready    = 1'b0;
    next_s.pslverr   = 1'b0;
    next_s.req.valid = 1'b0;
    // pads and the rtc clock are asynchronous; only the
    // second flop of each pair is read by any logic, the
    // first one may still be settling
    // pin and rtc synchronisers
    next_s.sync1  = pins_in;
    next_s.sync2  = s.sync1;
    next_s.rtc_s1 = rtc_clk_src;
    next_s.rtc_s2 = s.rtc_s1;
    next_s.div    = s.div + 3'h1;
    // a pin with its buffer off reads zero and keeps prev
    // at zero, so turning the buffer back on can show one
    // edge hit; software should clear flags after that
    // per-pin sampling and sensing
    for (int p = 0; p < 8; p++) begin
      for (int b = 0; b < 8; b++) begin
        // [RULE5] buffer off on first ports
        isbuf = (s.pincfg[p][b][2:0] == `SENSE_OFF) && (3'(p) < `BUF_PORTS);
        // [RULE3] unsampled pin reads zero
        lvl = isbuf ? 1'b0 : s.sync2[p][b];
        // [RULE2] sense decides hits
        hit = sense_eval(s.pincfg[p][b][2:0], lvl, s.prev[p][b]);
        next_s.level[p][b]   = lvl;
        next_s.prev[p][b]    = lvl;
        next_s.irq_hit[p][b] = hit[1];
        next_s.ev_hit[p][b]  = hit[0];
      end
    end
    // local registers answer one cycle after the access
    // edge; virtual windows take one more cycle so the
    // physical port can return its read data
    // register bus
    case (s.st)
      ST_IDLE: begin
        if (psel && penable) begin
          next_s.st     = ST_ACK;
          next_s.pready = 1'b1;
          if (paddr[1:0] != 2'h0) begin
            // misaligned address
            next_s.pslverr = 1'b1;
          end else if (idx == `IDX_GROUP_MASK) begin
            rd = s.group_mask;
            if (wr) begin
              next_s.group_mask = d;
            end
          end else if (idx == `IDX_VMAP_A) begin
            // [RULE9] map a fields
            rd = s.vmap_a;
            if (wr) begin
              next_s.vmap_a = d;
            end
          end else if (idx == `IDX_VMAP_B) begin
            // [RULE10] map b fields
            rd = s.vmap_b;
            if (wr) begin
              next_s.vmap_b = d;
            end
          end else if (idx == `IDX_CLKEV) begin
            rd = s.clkev;
            if (wr) begin
              next_s.clkev = d;
            end
          end else if (idx == `IDX_EVENT_OUTPUT_CONTROL) begin
            // reserved bits read zero, writes dropped
            rd = {6'h00, s.evsel};
            if (wr) begin
              next_s.evsel = d[1:0];
            end
          end else if (idx[9:6] == `PINCFG_TAG) begin
            rd = s.pincfg[idx[5:3]][idx[2:0]];
            if (wr) begin
              if (s.group_mask != 8'h00) begin
                // the addressed pin itself is skipped unless it
                // is also in the mask
                // [RULE7] group write to masked pins
                for (int b = 0; b < 8; b++) begin
                  if (s.group_mask[b]) begin
                    next_s.pincfg[idx[5:3]][b] = d;
                  end
                end
              end else begin
                // single pin write
                next_s.pincfg[idx[5:3]][idx[2:0]] = d;
              end
              // [RULE8] mask self clears
              next_s.group_mask = 8'h00;
            end
          end else if (idx[9:4] == `VPORT_TAG) begin
            case (idx[3:2])
              2'h0:    code = s.vmap_a[3:0];
              2'h1:    code = s.vmap_a[7:4];
              2'h2:    code = s.vmap_b[3:0];
              default: code = s.vmap_b[7:4];
            endcase
            dec = map_decode(code);
            if (dec[3]) begin
              // [RULE11] forward to physical register
              next_s.st        = ST_VPORT;
              next_s.pready    = 1'b0;
              next_s.req.valid = 1'b1;
              next_s.req.write = wr;
              next_s.req.port  = dec[2:0];
              next_s.req.sel   = idx[1:0];
              next_s.req.wdata = d;
            end else begin
              // [RULE23] unmapped virtual port
              next_s.pslverr = 1'b1;
            end
          end else begin
            // unmapped address
            next_s.pslverr = 1'b1;
          end
          next_s.prdata = {24'h000000, rd};
        end
      end
      ST_VPORT: begin
        // the physical register block must put its data on
        // vp_rdata while vp_req.valid is high
        // physical port answers during request cycle
        next_s.st     = ST_ACK;
        next_s.pready = 1'b1;
        next_s.prdata = {24'h000000, vp_rdata};
      end
      ST_ACK: begin
        // penable may still be high here, so this state
        // keeps the same transfer from being taken twice
        // transfer completes at this edge
        next_s.st = ST_IDLE;
      end
      default: begin
        // illegal one-hot code, recover to idle
        next_s.st = ST_IDLE;
      end
    endcase
    // the routed clocks are square waves from the free
    // running divider, taken from the registered state so
    // the pin never sees a combinational glitch; the pin
    // itself therefore toggles at most once per cycle
    // [RULE18] routed clock rate
    case (s.clkev[`CE_RATE_LSB +: 2])
      `RATE_1X: begin
        clk_lvl = s.div[2];
        clk_ok  = 1'b1;
      end
      `RATE_2X: begin
        clk_lvl = s.div[1];
        clk_ok  = 1'b1;
      end
      `RATE_4X: begin
        clk_lvl = s.div[0];
        clk_ok  = 1'b1;
      end
      // [RULE23] reserved rate
      default: begin
        clk_lvl = 1'b0;
        clk_ok  = 1'b0;
      end
    endcase
    // event channels share this clock, so they are read
    // without a synchroniser
    // [RULE22] event channel choice
    ev_lvl = ev_channel[s.evsel];
    next_s.drv_c = route(`ROUTE_PC, s.clkev, ev_lvl, clk_lvl, clk_ok,
                         1'b1, s.rtc_s2, dir_c);
    next_s.drv_e = route(`ROUTE_PE, s.clkev, ev_lvl, clk_lvl, clk_ok,
                         1'b0, 1'b0, dir_e);
  end

  // reset loads constants only; the asynchronous branch
  // must never depend on other state, or release of
  // reset could capture an unsettled value
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // everything zero, sequencer idle
      s          <= '0;
      s.st       <= ST_IDLE;
      s.group_mask <= `RST_REG;
      s.vmap_a   <= `RST_REG;
      s.vmap_b   <= `RST_REG;
      // [RULE24] outputs disabled at reset
      s.clkev    <= `RST_CLKEV;
    end else begin
      // register the whole next state at once
      s <= next_s;
    end
  end

  // outputs straight from state flops
  // one-cycle answer strobe
  assign pready         = s.pready;
  // read data, held until next answer
  assign prdata         = s.prdata;
  // error flag, valid with pready
  assign pslverr        = s.pslverr;
  // synchronised pin levels
  assign sampled_levels = s.level;
  // interrupt hits per pin
  assign sense_irq      = s.irq_hit;
  // event hits per pin
  assign sense_event    = s.ev_hit;
  // pin configuration bytes
  assign pin_config     = s.pincfg;
  // forwarded register access
  assign vp_req         = s.req;
  // port c override drive
  assign drive_c        = s.drv_c;
  // port e override drive
  assign drive_e        = s.drv_e;

endmodule : port_cfg

//--- verification/port_cfg_checker.sv
`timescale 1ns/10ps
module port_cfg_checker import port_cfg_pkg::*; (
  // clock, reset and bus
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  // port side
  input wire logic [7:0]  dir_c,
  input wire logic [7:0]  dir_e,
  input wire pin_bank_t   sampled_levels,
  input wire pin_cfg_t    pin_config,
  input wire vport_req_t  vp_req,
  input wire alt_drive_t  drive_c,
  input wire alt_drive_t  drive_e
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // first access edge of a transfer
  sequence s_first_access; psel && penable && !pready && !$past(penable); endsequence
  // forwarded access answered one cycle later
  sequence s_fwd_answer; ##1 (pready && !vp_req.valid); endsequence
  property p_answer_time; s_first_access |-> ##[1:2] pready; endproperty
  property p_pready_pulse; pready |=> !pready; endproperty
  property p_fwd_answer; vp_req.valid |-> s_fwd_answer; endproperty
  property p_fwd_cause; vp_req.valid |-> $past(psel && penable); endproperty
  property p_err_zero; pslverr |-> pready && prdata == 32'h0; endproperty
  property p_dir_c; (drive_c.en & ~$past(dir_c)) == 8'h0; endproperty
  property p_dir_e; (drive_e.en & ~$past(dir_e)) == 8'h0; endproperty
  property p_buf_off; pin_config[0][0][2:0] == 3'h7 && $past(pin_config[0][0][2:0]) == 3'h7 |-> !sampled_levels[0][0];
  endproperty
  property p_cfg_by_write; $changed(pin_config) |-> $past(psel && penable && pwrite); endproperty
  a_answer_time: assert property (p_answer_time)
    else $error("bus answer late");
  a_pready_pulse: assert property (p_pready_pulse)
    else $error("pready longer than one cycle");
  a_fwd_answer: assert property (p_fwd_answer)
    else $error("forwarded access not answered");
  a_fwd_cause: assert property (p_fwd_cause)
    else $error("forwarded access without bus access");
  a_err_zero: assert property (p_err_zero)
    else $error("error answer with data");
  a_dir_c: assert property (p_dir_c)
    else $error("port c drives input pin");
  a_dir_e: assert property (p_dir_e)
    else $error("port e drives input pin");
  a_buf_off: assert property (p_buf_off)
    else $error("disabled buffer still sampled");
  a_cfg_by_write: assert property (p_cfg_by_write)
    else $error("pin config changed without write");
endmodule : port_cfg_checker

//--- verification/tb.sv
`timescale 1ns/10ps
module tb import port_cfg_pkg::*; ;
  // bench signals
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rtc_clk_src = 0;
  logic        pready, pslverr, er, last7;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0]  pstrb = 4'h1, ev_channel = 0;
  logic [7:0]  dir_c = 0, dir_e = 0, vp_rdata = 0;
  logic [3:0]  codes [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'hb, 4'hf};
  logic [2:0]  sc [5] = '{3'h3, 3'h1, 3'h2, 3'h0, 3'h4};
  pin_bank_t   pins_in = 0, sampled_levels, sense_irq, sense_event;
  pin_cfg_t    pin_config;
  vport_req_t  vp_req, seen;
  alt_drive_t  drive_c, drive_e;
  int          mismatches = 0, checks = 0, tog = 0, hits [5];
  // 200 MHz clock
  always #2.5 pclk = ~pclk;
  port_cfg uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .pins_in(pins_in), .rtc_clk_src(rtc_clk_src), .ev_channel(ev_channel), .dir_c(dir_c), .dir_e(dir_e),
    .vp_rdata(vp_rdata), .sampled_levels(sampled_levels), .sense_irq(sense_irq), .sense_event(sense_event),
    .pin_config(pin_config), .vp_req(vp_req), .drive_c(drive_c), .drive_e(drive_e));
  // latch forwarded access, count clock toggles and sense hits
  always @(posedge pclk) begin
    if (vp_req.valid === 1'b1) seen <= vp_req;
    tog <= tog + 32'(drive_c.out[7] !== last7);
    last7 <= drive_c.out[7];
    for (int i = 0; i < 5; i++) hits[i] <= hits[i] + 32'(sense_irq[1][i]);
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // one apb transfer, waits for pready under a bound
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) mismatches++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic w(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask : w
  task automatic rdchk(input logic [11:0] a, input logic [7:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    check(rd, {24'h0, e});
    check(32'(er), 32'(ee));
  endtask : rdchk
  // write through a virtual window, check the forwarded access
  task automatic vwr(input logic [11:0] a, input logic [2:0] p);
    apb(1'b1, a, 32'h5a);
    check({18'h0, seen.write, seen.port, seen.sel, seen.wdata}, {18'h0, 1'b1, p, a[3:2], 8'h5a});
  endtask : vwr
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : settle
  task automatic report_and_stop();
    if (mismatches == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  // hang guard
  initial begin
    #50000;
    mismatches++;
    report_and_stop();
  end
  // main sequence
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(12'h010, 8'h00, 1'b0);
    rdchk(12'h004, 8'h00, 1'b1);
    for (int i = 0; i < 8; i++) begin
      w(12'h008, {codes[i], 4'h2});
      vp_rdata <= 8'ha0 + 8'(i);
      vwr(12'h214, 3'(i));
      apb(1'b0, 12'h218, 32'h0);
      check(rd, 32'ha0 + 32'(i));
      check({26'h0, seen.write, seen.port, seen.sel}, {26'h0, 1'b0, 3'(i), 2'h2});
    end
    vwr(12'h204, 3'h2);
    rdchk(12'h008, 8'hf2, 1'b0);
    pstrb <= 4'h0;
    w(12'h008, 8'h33);
    pstrb <= 4'h1;
    rdchk(12'h008, 8'hf2, 1'b0);
    w(12'h00c, 8'hb4);
    vwr(12'h224, 3'h4);
    vwr(12'h234, 3'h6);
    w(12'h00c, 8'h05);
    rdchk(12'h220, 8'h00, 1'b1);
    // group mask write, then plain write
    w(12'h000, 8'h05);
    w(12'h144, 8'h03);
    check({8'h0, pin_config[2][2:0]}, 32'h030003);
    rdchk(12'h000, 8'h00, 1'b0);
    w(12'h144, 8'h02);
    check({8'h0, pin_config[2][2:0]}, 32'h030203);
    // off code on port 0 and port 5, buffer off only on port 0
    w(12'h100, 8'h07);
    w(12'h1a0, 8'h07);
    @(posedge pclk);
    pins_in[0] <= 8'h03;
    pins_in[5] <= 8'h01;
    settle(6);
    check(32'(sampled_levels[0][1:0]), 32'h2);
    check(32'(sampled_levels[5][0]), 32'h1);
    // sense codes on port 1 pins 0..4
    for (int i = 0; i < 5; i++) w(12'h120 + 12'(4 * i), {5'h0, sc[i]});
    settle(4);
    hits = '{default: 0};
    @(posedge pclk);
    pins_in[1] <= 8'h1f;
    settle(8);
    check(32'(sense_event[1][0]), 32'h1);
    settle(1);
    check(32'(sense_event[1][0]), 32'h1);
    @(posedge pclk);
    pins_in[1] <= 8'h00;
    settle(8);
    check({sense_event[1][0], sense_irq[1][0]}, 32'h1);
    check({hits[1][7:0], hits[2][7:0], hits[3][7:0], hits[4][7:0]}, 32'h01010200);
    // clock rates on port c pin 7, reserved rate fourth, then 4x with event also on port c
    @(posedge pclk);
    dir_c <= 8'hff;
    dir_e <= 8'hff;
    for (int r = 0; r < 5; r++) begin
      w(12'h010, (r == 4) ? 8'h19 : {4'h0, 2'(r), 2'h1});
      settle(2);
      tog = 0;
      settle(16);
      check(tog, (r == 3) ? 0 : (r == 4) ? 16 : 4 << r);
      check(32'(drive_c.en[7]), 32'(r != 3));
    end
    w(12'h010, 8'h30);
    for (int ch = 0; ch < 4; ch++) begin
      w(12'h018, 8'(ch));
      ev_channel <= 4'h1 << ch;
      settle(2);
      check({drive_e.en[7], drive_e.out[7]}, 32'h3);
      @(posedge pclk);
      ev_channel <= ~(4'h1 << ch);
      settle(2);
      check(32'(drive_e.out[7]), 32'h0);
    end
    @(posedge pclk);
    dir_e <= 8'h7f;
    settle(2);
    check(32'(drive_e.en[7]), 32'h0);
    w(12'h010, 8'h20);
    settle(2);
    check({drive_c.en, drive_e.en}, 32'h0);
    w(12'h010, 8'h89);
    settle(2);
    check({drive_c.en[7], drive_c.en[4]}, 32'h1);
    w(12'h010, 8'h40);
    rtc_clk_src <= 1'b1;
    settle(5);
    check({drive_c.en[6], drive_c.out[6]}, 32'h3);
    @(posedge pclk);
    rtc_clk_src <= 1'b0;
    settle(5);
    check(32'(drive_c.out[6]), 32'h0);
    report_and_stop();
  end
endmodule : tb
bind port_cfg port_cfg_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .prdata(prdata), .dir_c(dir_c), .dir_e(dir_e),
  .sampled_levels(sampled_levels), .pin_config(pin_config), .vp_req(vp_req), .drive_c(drive_c),
  .drive_e(drive_e));
